// ==== core/sld_pkg.sv ====
// Constants and types shared by both ends of the serial segment driver link.
// Assumes a 250 MHz system clock at the source end.
package sld_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Frame format
  localparam int FRAME_CLOCKS = 36;
  localparam int DATA_BITS = 32;
  localparam int SEG_MAX = 33;
  localparam logic START_BIT = 1'b1;
  localparam int FIFO_DEPTH = 16;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SHIFT_HALF_NS = 500;
  localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BP_FREQ_HZ = 75;
  localparam longint BP_HALF_CYC = 64'd1000000000000 / (CLK_PERIOD_PS * 2 * BP_FREQ_HZ);
  localparam int OSC_DIV_DEF = 64;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic SHIFT_CLK_RST = 1'b0;
  localparam logic XFER_EN_N_RST = 1'b1;
  localparam logic BP_RST = 1'b0;

  typedef enum logic [1:0] {
    SLD_IDLE,
    SLD_LOW,
    SLD_HIGH,
    SLD_TAIL
  } sld_src_state_t;

endpackage

// ==== core/sld_link_if.sv ====
// Link between the serial data source and the segment driver.
// Assumes the bench joins the source modport to the driver modport.
`timescale 1ns/10ps
interface sld_link_if;
  logic shift_clk;
  logic ser_data;
  logic xfer_en_n;
  logic bp_clk;
  logic osc_en;

  modport src
  (
    output shift_clk,
    output ser_data,
    output xfer_en_n,
    output bp_clk,
    output osc_en
  );

  modport drv
  (
    input shift_clk,
    input ser_data,
    input xfer_en_n,
    input bp_clk,
    input osc_en
  );
endinterface

// ==== core/sld_drv.sv ====
// Segment driver end: serial shift register, frame counter, output latches
// and backplane drive.
// Assumes data and enable are set up by the source around the link clock,
// which only runs during frames; osc_clk is the oscillator input.
`timescale 1ns/10ps

module sld_drv #(
  parameter bit HAS_ENABLE = 1'b1,
  parameter int OSC_DIV = sld_pkg::OSC_DIV_DEF
)
(
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic osc_clk,
  sld_link_if.drv link,
  output logic [sld_pkg::SEG_MAX-1:0] seg_out,
  output logic bp_out,
  output logic [sld_pkg::SEG_MAX-1:0] latch_q,
  output logic frame_loaded
);

  localparam int NB = HAS_ENABLE ? sld_pkg::DATA_BITS : sld_pkg::SEG_MAX;
  localparam int OW = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  localparam logic [5:0] LAST_CLK = 6'(sld_pkg::FRAME_CLOCKS - 1);
  localparam logic [5:0] LAST_DATA = 6'(NB);

  //////////////////////////////////////////////////////////////////////////////
  // Frame control on the link clock

  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [sld_pkg::SEG_MAX-1:0] shreg;
  logic [sld_pkg::SEG_MAX-1:0] next_shreg;
  logic [sld_pkg::SEG_MAX-1:0] latch;

  wire logic din;
  wire logic gate_open;
  wire logic take;
  wire logic idle;
  wire logic start_seen;
  wire logic shift_now;
  wire logic load_now;
  wire logic bp_level;

  assign din = link.ser_data;
  assign gate_open = ~HAS_ENABLE | ~link.xfer_en_n;
  assign take = clk_en & gate_open;
  assign idle = (cnt == 6'h00);
  assign start_seen = idle & (din == sld_pkg::START_BIT);
  assign shift_now = take & ~idle & (cnt <= LAST_DATA);
  assign load_now = take & (cnt == LAST_CLK);

  always_comb
  begin
    next_cnt = cnt;
    if (take)
    begin
      if (idle)
      begin
        next_cnt = start_seen ? 6'h01 : 6'h00;
      end
      else if (load_now)
      begin
        next_cnt = 6'h00;
      end
      else
      begin
        next_cnt = cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge link.shift_clk)
  begin
    if (sys_rst)
    begin
      cnt <= 6'h00;
    end
    else
    begin
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge link.shift_clk)
  begin
    if (sys_rst)
    begin
      frame_loaded <= 1'b0;
    end
    else if (clk_en)
    begin
      frame_loaded <= load_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-bit shift stage, latch and segment drive

  genvar i;
  generate
    for (i = 0; i < sld_pkg::SEG_MAX; i = i + 1)
    begin : g_bit
      if (i < NB - 1)
      begin : g_mid
        assign next_shreg[i] = shreg[i + 1];
      end
      else if (i == NB - 1)
      begin : g_top
        assign next_shreg[i] = din;
      end
      else
      begin : g_none
        assign next_shreg[i] = 1'b0;
      end

      always_ff @(posedge link.shift_clk)
      begin
        if (sys_rst)
        begin
          shreg[i] <= 1'b0;
        end
        else if (load_now)
        begin
          shreg[i] <= 1'b0;
        end
        else if (shift_now)
        begin
          shreg[i] <= next_shreg[i];
        end
      end

      always_ff @(posedge link.shift_clk)
      begin
        if (sys_rst)
        begin
          latch[i] <= 1'b0;
        end
        else if (load_now && (latch[i] != shreg[i]))
        begin
          latch[i] <= shreg[i];
        end
      end

      if (i < NB)
      begin : g_seg
        assign seg_out[i] = latch[i] ^ bp_level;
      end
      else
      begin : g_off
        assign seg_out[i] = 1'b0;
      end
    end
  endgenerate

  assign latch_q = latch;

  //////////////////////////////////////////////////////////////////////////////
  // Internal oscillator and backplane select

  logic en_meta;
  logic en_sync;
  logic [OW-1:0] osc_cnt;
  logic bp_int;

  wire logic osc_wrap;

  assign osc_wrap = (osc_cnt == OW'(OSC_DIV - 1));

  always_ff @(posedge osc_clk)
  begin
    if (sys_rst)
    begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
    end
    else if (clk_en)
    begin
      en_meta <= link.osc_en;
      en_sync <= en_meta;
    end
  end

  always_ff @(posedge osc_clk)
  begin
    if (sys_rst)
    begin
      osc_cnt <= '0;
    end
    else if (clk_en)
    begin
      osc_cnt <= (osc_wrap || !en_sync) ? '0 : osc_cnt + OW'(1);
    end
  end

  always_ff @(posedge osc_clk)
  begin
    if (sys_rst)
    begin
      bp_int <= sld_pkg::BP_RST;
    end
    else if (clk_en && !en_sync)
    begin
      bp_int <= sld_pkg::BP_RST;
    end
    else if (clk_en && osc_wrap)
    begin
      bp_int <= ~bp_int;
    end
  end

  // External clock drives the backplane directly when the oscillator is off
  assign bp_level = en_sync ? bp_int : link.bp_clk;
  assign bp_out = bp_level;

endmodule // sld_drv

// ==== core/sld_src.sv ====
// Data source end: frame FIFO, frame serialiser with derived link clock,
// and external backplane clock generator.
// Assumes clk at 250 MHz with synchronous active-high sys_rst.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Frame FIFO
module sld_fifo #(
  parameter int WIDTH = sld_pkg::DATA_BITS,
  parameter int DEPTH = sld_pkg::FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;

  wire logic push;
  wire logic pop;

  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign push = clk_en & in_valid & in_ready;
  assign pop = clk_en & out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

endmodule // sld_fifo

////////////////////////////////////////////////////////////////////////////////
// Source
module sld_src #(
  parameter int NBITS = sld_pkg::DATA_BITS,
  parameter int HALF = sld_pkg::SHIFT_HALF_CYC,
  parameter int BP_HALF = int'(sld_pkg::BP_HALF_CYC)
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic use_ext_bp,
  input wire logic [NBITS-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic busy,
  sld_link_if.src link
);

  localparam int PW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam int BW = (BP_HALF > 1) ? $clog2(BP_HALF) : 1;
  localparam logic [5:0] LAST_CLK = 6'(sld_pkg::FRAME_CLOCKS - 1);

  sld_pkg::sld_src_state_t state;
  logic [PW-1:0] phase;
  logic [5:0] bit_no;
  logic [NBITS-1:0] frame;
  logic shift_clk;
  logic ser_data;
  logic xfer_en_n;
  logic [BW-1:0] bp_cnt;
  logic bp_clk;

  wire logic [NBITS-1:0] fifo_data;
  wire logic fifo_valid;
  wire logic pop;
  wire logic phase_done;
  wire logic more_data;

  sld_fifo #(.WIDTH(NBITS), .DEPTH(sld_pkg::FIFO_DEPTH)) u_fifo
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  assign pop = (state == sld_pkg::SLD_IDLE) & fifo_valid;
  assign phase_done = (phase == PW'(HALF - 1));
  assign more_data = (bit_no < 6'(NBITS));
  assign busy = (state != sld_pkg::SLD_IDLE);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      phase <= '0;
    end
    else if (clk_en)
    begin
      phase <= (state == sld_pkg::SLD_IDLE || phase_done) ? '0 : phase + PW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= sld_pkg::SLD_IDLE;
      bit_no <= 6'h00;
      frame <= '0;
      shift_clk <= sld_pkg::SHIFT_CLK_RST;
      ser_data <= 1'b0;
      xfer_en_n <= sld_pkg::XFER_EN_N_RST;
    end
    else if (clk_en)
    begin
      unique case (state)
        sld_pkg::SLD_IDLE:
        begin
          if (fifo_valid)
          begin
            frame <= fifo_data;
            bit_no <= 6'h00;
            ser_data <= sld_pkg::START_BIT;
            xfer_en_n <= 1'b0;
            state <= sld_pkg::SLD_LOW;
          end
        end
        sld_pkg::SLD_LOW:
        begin
          if (phase_done)
          begin
            shift_clk <= 1'b1;
            state <= sld_pkg::SLD_HIGH;
          end
        end
        sld_pkg::SLD_HIGH:
        begin
          if (phase_done)
          begin
            shift_clk <= 1'b0;
            if (bit_no == LAST_CLK)
            begin
              state <= sld_pkg::SLD_TAIL;
            end
            else
            begin
              bit_no <= bit_no + 6'h01;
              ser_data <= more_data ? frame[0] : 1'b0;
              frame <= frame >> 1;
              state <= sld_pkg::SLD_LOW;
            end
          end
        end
        sld_pkg::SLD_TAIL:
        begin
          if (phase_done)
          begin
            xfer_en_n <= 1'b1;
            ser_data <= 1'b0;
            state <= sld_pkg::SLD_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // External backplane clock: toggle flip-flop for an exact 50% duty

  always_ff @(posedge clk)
  begin
    if (sys_rst || !use_ext_bp)
    begin
      bp_cnt <= '0;
      bp_clk <= sld_pkg::BP_RST;
    end
    else if (clk_en)
    begin
      if (bp_cnt == BW'(BP_HALF - 1))
      begin
        bp_cnt <= '0;
        bp_clk <= ~bp_clk;
      end
      else
      begin
        bp_cnt <= bp_cnt + BW'(1);
      end
    end
  end

  assign link.shift_clk = shift_clk;
  assign link.ser_data = ser_data;
  assign link.xfer_en_n = xfer_en_n;
  assign link.bp_clk = bp_clk;
  assign link.osc_en = ~use_ext_bp;

endmodule // sld_src

// ==== sim/sld_asserts.sv ====
// Assertions on the source-to-driver link wires.
// Assumes every link output except osc_en is launched from a flop on clk; osc_en is ~use_ext_bp.
`timescale 1ns/10ps
module sld_asserts #(
  parameter int HALF = 4,
  parameter int BP_HALF = 8
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic shift_clk,
  input wire logic ser_data,
  input wire logic xfer_en_n,
  input wire logic bp_clk,
  input wire logic osc_en
);
  int hi_n;
  int edg_n;
  int bp_n;
  logic bp_seen;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Counts of clock high time, frame edges and backplane half period
  always_ff @(posedge clk)
  begin
    hi_n <= (sys_rst || !shift_clk) ? 0 : hi_n + 1;
    edg_n <= (sys_rst || xfer_en_n) ? 0 : edg_n + int'($rose(shift_clk));
    bp_n <= (sys_rst || $changed(bp_clk)) ? 1 : bp_n + 1;
    bp_seen <= (sys_rst || osc_en) ? 1'b0 : (bp_seen | $changed(bp_clk));
  end
  ////////////////////////////////////////
  property p_idle_still;
    xfer_en_n |-> !shift_clk;
  endproperty
  a_idle_still: assert property (p_idle_still)
    else $error("link clock runs while idle");
  property p_start_bit;
    $fell(xfer_en_n) |-> ser_data && !shift_clk;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("frame opens without start bit");
  property p_first_one;
    $rose(shift_clk) && edg_n == 0 |-> ser_data;
  endproperty
  a_first_one: assert property (p_first_one)
    else $error("first edge not a one");
  property p_pad_zero;
    $rose(shift_clk) && edg_n >= 33 |-> !ser_data;
  endproperty
  a_pad_zero: assert property (p_pad_zero)
    else $error("pad bit not zero");
  property p_data_hold;
    shift_clk && $past(shift_clk) |-> $stable(ser_data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data moved while clock high");
  property p_high_len;
    $fell(shift_clk) |-> hi_n == HALF;
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("clock high time wrong");
  property p_frame_len;
    $rose(xfer_en_n) |-> edg_n == 36 && !ser_data;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame edge count wrong");
  property p_osc_off;
    osc_en && $past(osc_en) |-> !bp_clk;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("backplane clock runs with oscillator on");
  property p_bp_duty;
    $changed(bp_clk) && bp_seen && !osc_en |-> bp_n == BP_HALF;
  endproperty
  a_bp_duty: assert property (p_bp_duty)
    else $error("backplane half period wrong");
endmodule // sld_asserts

// ==== sim/serial_lcd_segment_driver_tb.sv ====
// Bench for source and drivers; a second link is bit-banged by the bench.
// Assumes the design files under core/ are compiled first.
`timescale 1ns/10ps
module serial_lcd_segment_driver_tb;
  localparam int HALF = 4;
  localparam int BPH = 8;
  logic clk = 1'b0;
  logic osc_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic drv_rst = 1'b1;
  logic run = 1'b1;
  logic use_ext_bp = 1'b1;
  logic [31:0] in_data = 32'h0;
  logic in_valid = 1'b0;
  logic in_ready, busy, bp_a, bp_e, bp_p, ld_a;
  logic [32:0] seg_a, seg_e, seg_p, lat_a, lat_e, lat_p;
  logic [31:0] rnd = 32'h00010f17;
  logic [31:0] exp_q[$] = '{32'h0, 32'hffffffff, 32'h1, 32'h80000000};
  int n_fail = 0;
  int tests_run = 0;
  sld_link_if link();
  sld_link_if link2();
  initial forever #2 clk = ~clk;
  initial forever #15 osc_clk = ~osc_clk;
  sld_src #(.HALF(HALF), .BP_HALF(BPH)) sld_src_inst
  (
    .clk(clk), .sys_rst(sys_rst), .clk_en(run), .use_ext_bp(use_ext_bp),
    .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready), .busy(busy),
    .link(link.src)
  );
  sld_drv #(.OSC_DIV(4)) sld_drv_inst
  (
    .sys_rst(drv_rst), .clk_en(run), .osc_clk(osc_clk), .link(link.drv),
    .seg_out(seg_a), .bp_out(bp_a), .latch_q(lat_a), .frame_loaded(ld_a)
  );
  sld_drv #(.OSC_DIV(4)) sld_drv_inst_e
  (
    .sys_rst(drv_rst), .clk_en(run), .osc_clk(osc_clk), .link(link2.drv),
    .seg_out(seg_e), .bp_out(bp_e), .latch_q(lat_e), .frame_loaded()
  );
  sld_drv #(.HAS_ENABLE(1'b0), .OSC_DIV(4)) sld_drv_inst_p
  (
    .sys_rst(drv_rst), .clk_en(run), .osc_clk(osc_clk), .link(link2.drv),
    .seg_out(seg_p), .bp_out(bp_p), .latch_q(lat_p), .frame_loaded()
  );
  sld_asserts #(.HALF(HALF), .BP_HALF(BPH)) sld_asserts_inst
  (
    .clk(clk), .sys_rst(sys_rst), .shift_clk(link.shift_clk), .ser_data(link.ser_data),
    .xfer_en_n(link.xfer_en_n), .bp_clk(link.bp_clk), .osc_en(link.osc_en)
  );
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [32:0] segs(input logic [32:0] l, input logic b, input logic en);
    return (l ^ {33{b}}) & {~en, 32'hffffffff};
  endfunction
  task automatic summarize();
    $display("Compared %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input bit on_ld, input logic v);
    int k;
    k = 0;
    while ((on_ld ? ld_a : busy) !== v && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 3000)
    begin
      n_fail++;
      summarize();
    end
  endtask
  // Start bit, 33 bits, zero pad: 36 link clocks
  task automatic send2(input logic en_n, input logic [32:0] d);
    logic [35:0] f;
    f = {2'b00, d, 1'b1};
    link2.xfer_en_n = en_n;
    for (int i = 0; i < 36; i++)
    begin
      link2.ser_data = f[i];
      #15 link2.shift_clk = 1'b1;
      #15 link2.shift_clk = 1'b0;
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    int n;
    int k;
    logic p;
    logic [32:0] d;
    logic [32:0] d2;
    link2.shift_clk = 1'b0;
    link2.ser_data = 1'b0;
    link2.xfer_en_n = 1'b1;
    link2.bp_clk = 1'b0;
    link2.osc_en = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      exp_q.push_back(rnd);
      rnd = lfsr(rnd);
    end
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    in_valid = 1'b1;
    @(negedge clk);
    in_valid = 1'b0;
    send2(1'b0, 33'h0);
    link2.ser_data = 1'b1;
    wait_for(1'b0, 1'b0);
    drv_rst = 1'b0;
    chk(lat_a, 33'h0);
    chk(lat_e, 33'h0);
    chk(lat_p, 33'h0);
    n = 0;
    in_valid = 1'b1;
    while (n < 20 && in_ready === 1'b1)
    begin
      in_data = exp_q[n];
      @(negedge clk);
      n++;
    end
    in_valid = 1'b0;
    chk(33'(in_ready), 33'h0);
    chk(33'(n >= 16), 33'h1);
    for (int i = 0; i < n; i++)
    begin
      wait_for(1'b1, 1'b1);
      chk(lat_a, {1'b0, exp_q[i]});
      chk(seg_a, segs({1'b0, exp_q[i]}, bp_a, 1'b1));
      if (use_ext_bp)
        chk(33'(bp_a), 33'(link.bp_clk));
      use_ext_bp = i < 8;
      repeat (16) @(negedge clk);
    end
    k = 0;
    repeat (200)
    begin
      p = bp_a;
      @(negedge clk);
      k += int'(bp_a !== p);
    end
    chk(33'(k > 3), 33'h1);
    chk(33'(link.osc_en), 33'h1);
    d = {rnd[7], rnd};
    rnd = lfsr(rnd);
    d2 = {rnd[3], rnd};
    send2(1'b0, d);
    chk(lat_e, {1'b0, d[31:0]});
    chk(lat_p, d);
    send2(1'b1, d2);
    link2.xfer_en_n = 1'b1;
    link2.ser_data = 1'b1;
    chk(lat_e, {1'b0, d[31:0]});
    chk(lat_p, d2);
    chk(seg_p, segs(d2, bp_p, 1'b0));
    chk(seg_e, segs({1'b0, d[31:0]}, bp_e, 1'b1));
    summarize();
  end
endmodule // serial_lcd_segment_driver_tb
